// *** core/function_box.sv ***
// 24-bit function box: arithmetic and logical results plus condition groups.
// Assumes operands, carry flag and control fields are registered upstream.
`timescale 1ns/100ps
`include "function_box_params.svh"
module function_box
    import function_box_pkg::*;
#(
    parameter int WIDTH = `FB_DATA_W,
    parameter int LW = `FB_LEN_W
) (
    input wire logic mclk,
    input wire logic arst_n,
    input function_box_pkg::word_t first_operand,
    input function_box_pkg::word_t second_operand,
    input wire logic carry_flag,
    input function_box_pkg::unit_mode_t unit_mode,
    input function_box_pkg::len_t operand_length,
    input function_box_pkg::group_t port_condition_lines,
    input function_box_pkg::group_t panel_request_flags,
    input function_box_pkg::group_t memory_fault_flags,
    output function_box_pkg::word_t sum_result,
    output function_box_pkg::word_t subtract_result,
    output function_box_pkg::word_t and_result,
    output function_box_pkg::word_t or_result,
    output function_box_pkg::word_t xor_result,
    output function_box_pkg::word_t first_operand_complement,
    output function_box_pkg::word_t second_operand_complement,
    output function_box_pkg::word_t first_operand_masked,
    output function_box_pkg::word_t second_operand_masked,
    output function_box_pkg::group_t binary_condition_group,
    output function_box_pkg::group_t relational_condition_group,
    output function_box_pkg::group_t operand_state_group,
    output function_box_pkg::ctrl_t carry_length_control_group
);
    import function_box_pkg::*;

    // Clock and reset are accepted for uniformity; nothing is stored
    wire logic clock_unused;
    assign clock_unused = mclk & arst_n;

    wire logic unit_select_bit;
    wire logic [WIDTH-1:0] len_mask;
    wire logic [WIDTH-1:0] add_raw;
    wire logic [WIDTH-1:0] sub_raw;
    wire logic [WIDTH:0] add_prefix;
    wire logic carry_out_level;
    wire logic borrow_out_level;
    wire logic first_least_unit_one;
    wire logic second_least_unit_one;
    wire logic length_selected_bit;
    wire logic summary_interrupt;
    wire logic equal_flag;
    wire logic less_flag;
    wire logic greater_flag;

    // Only the low control bit selects the unit: 10 and 11 alias 00 and 01
    assign unit_select_bit = unit_mode[0];

    length_mask #(
        .WIDTH(WIDTH),
        .LW(LW)
    ) u_mask (
        .length(operand_length),
        .mask(len_mask)
    );

    // Decimal path works on six digits; bad digit codes are undefined
    unit_adder #(
        .WIDTH(WIDTH),
        .DIGITS(`FB_DIGITS)
    ) u_add (
        .a(first_operand),
        .b(second_operand),
        .cin(carry_flag),
        .subtract(1'b0),
        .decimal(unit_select_bit),
        .result(add_raw),
        .carries()
    );

    // Ten's complement falls out of the nine's complement adder
    unit_adder #(
        .WIDTH(WIDTH),
        .DIGITS(`FB_DIGITS)
    ) u_sub (
        .a(first_operand),
        .b(second_operand),
        .cin(carry_flag),
        .subtract(1'b1),
        .decimal(unit_select_bit),
        .result(sub_raw),
        .carries()
    );

    // Zeroed above the length; lengths past 24 stay unmasked
    assign sum_result = add_raw & len_mask;
    assign subtract_result = sub_raw & len_mask;

    // Carry-out: the carry leaving bit (length-1) of the full sum. A prefix
    // sum per length keeps decimal and binary alike without a second adder.
    genvar p;
    generate
        for (p = 0; p <= WIDTH; p++) begin : g_pref
            if (p == 0) begin : g_zero
                assign add_prefix[p] = carry_flag;
            end else if (p % 4 == 0) begin : g_digit
                wire logic [p:0] bin_part;
                wire logic [WIDTH-1:0] km;
                assign bin_part = {1'b0, first_operand[p-1:0]}
                    + {1'b0, second_operand[p-1:0]} + (p+1)'(carry_flag);
                assign km = {{(WIDTH-p){1'b0}}, {p{1'b1}}};
                // Decimal digit carry: does the kept sum overflow p/4 digits
                assign add_prefix[p] = unit_select_bit
                    ? dec_carry(first_operand & km, second_operand & km,
                                carry_flag, p / 4)
                    : bin_part[p];
            end else begin : g_bin
                wire logic [p:0] bin_part;
                assign bin_part = {1'b0, first_operand[p-1:0]}
                    + {1'b0, second_operand[p-1:0]} + (p+1)'(carry_flag);
                assign add_prefix[p] = bin_part[p];
            end
        end
    endgenerate

    function automatic logic dec_carry(input word_t a, input word_t b,
                                       input logic cin, input int n);
        logic c;
        logic [4:0] s;
        c = cin;
        for (int i = 0; i < `FB_DIGITS; i++) begin
            if (i < n) begin
                s = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + 5'(c);
                c = s > 5'h09;
            end
        end
        return c;
    endfunction

    // Length 0 passes the carry flag; 1 uses the rightmost position
    assign carry_out_level = (32'(operand_length) <= WIDTH)
        ? add_prefix[operand_length] : 1'b0;

    // Static full-width compare, independent of length and mode
    assign equal_flag = first_operand == second_operand;
    assign less_flag = first_operand < second_operand;
    assign greater_flag = first_operand > second_operand;
    assign borrow_out_level = less_flag | (equal_flag & carry_flag);

    assign and_result = first_operand & second_operand & len_mask;
    assign or_result = (first_operand | second_operand) & len_mask;
    assign xor_result = (first_operand ^ second_operand) & len_mask;
    assign first_operand_complement = ~first_operand & len_mask;
    assign second_operand_complement = ~second_operand & len_mask;
    assign first_operand_masked = first_operand & len_mask;
    assign second_operand_masked = second_operand & len_mask;

    // Least unit is one bit in binary mode, a whole digit in decimal mode
    assign second_least_unit_one = unit_select_bit
        ? (second_operand[3:0] == `FB_BCD_ONE)
        : second_operand[0];
    assign first_least_unit_one = unit_select_bit
        ? (first_operand[3:0] == `FB_BCD_ONE)
        : first_operand[0];

    // Length 1 is the rightmost bit; 0 and out-of-range read zero
    assign length_selected_bit = (operand_length != '0)
        && (32'(operand_length) <= WIDTH)
        && first_operand[5'(operand_length - 5'h01)];

    // Hazard: these flags are sampled raw; a clear that lands between the
    // flag source and a test is the caller's concern, not the box's.
    assign summary_interrupt =
        port_condition_lines[`FB_PORT_MISSING_BIT]
        | port_condition_lines[`FB_PORT_INTR_BIT]
        | panel_request_flags[`FB_PANEL_TIMER_BIT]
        | panel_request_flags[`FB_PANEL_SERVICE_BIT]
        | panel_request_flags[`FB_PANEL_INTR_BIT]
        | memory_fault_flags[`FB_MEM_READ_ERR_BIT]
        | memory_fault_flags[`FB_MEM_WRITE_OOB_BIT];

    assign binary_condition_group = {second_least_unit_one, carry_flag,
        borrow_out_level, carry_out_level};
    assign relational_condition_group = {length_selected_bit, equal_flag,
        less_flag, greater_flag};
    assign operand_state_group = {first_least_unit_one, summary_interrupt,
        second_operand != '0, first_operand != '0};

    // Control group readback: carry flag on top, unit code, then length
    assign carry_length_control_group = {carry_flag, unit_mode,
        operand_length};
endmodule

// *** shared/function_box_params.svh ***
// Constants for the 24-bit function box: widths, unit sizes, bit positions.
// Assumes inclusion by bare name from package and design files.
`ifndef FUNCTION_BOX_PARAMS_SVH
`define FUNCTION_BOX_PARAMS_SVH
`define FB_DATA_W 24
`define FB_LEN_W 5
`define FB_UNIT_W 4
`define FB_DIGITS 6
`define FB_GROUP_W 4
`define FB_CTRL_W 8
`define FB_CTRL_CARRY_BIT 7
`define FB_CTRL_UNIT_LO 5
`define FB_CTRL_LEN_LO 0
`define FB_BCD_ONE 4'h9
`define FB_PORT_MISSING_BIT 3
`define FB_PORT_INTR_BIT 1
`define FB_PANEL_TIMER_BIT 2
`define FB_PANEL_SERVICE_BIT 1
`define FB_PANEL_INTR_BIT 0
`define FB_MEM_READ_ERR_BIT 3
`define FB_MEM_WRITE_OOB_BIT 0
`endif

// *** shared/function_box_pkg.sv ***
// Types shared by the function box design files.
// Assumes function_box_params.svh on the include path.
`include "function_box_params.svh"
package function_box_pkg;
    typedef logic [`FB_DATA_W-1:0] word_t;
    typedef logic [`FB_LEN_W-1:0] len_t;
    typedef logic [`FB_GROUP_W-1:0] group_t;
    typedef logic [`FB_CTRL_W-1:0] ctrl_t;
    typedef enum logic [1:0] {
        UNIT_BIN = 2'b00,
        UNIT_DEC = 2'b01,
        UNIT_BIN_ALT = 2'b10,
        UNIT_DEC_ALT = 2'b11
    } unit_mode_t;
endpackage

// *** core/length_mask.sv ***
// Builds the low-order keep mask for an operand length.
// Assumes length in 0..24; larger lengths give all ones (undefined).
`timescale 1ns/100ps
module length_mask #(
    parameter int WIDTH = 24,
    parameter int LW = 5
) (
    input wire logic [LW-1:0] length,
    output logic [WIDTH-1:0] mask
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign mask[i] = (32'(length) > i);
        end
    endgenerate
endmodule

// *** core/unit_adder.sv ***
// Adds or subtracts 24-bit words in 1-bit or 4-bit decimal units.
// Assumes valid decimal digits in decimal mode; others are undefined.
`timescale 1ns/100ps
`include "function_box_params.svh"
module unit_adder #(
    parameter int WIDTH = 24,
    parameter int DIGITS = 6
) (
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic cin,
    input wire logic subtract,
    input wire logic decimal,
    output logic [WIDTH-1:0] result,
    output logic [WIDTH:0] carries
);
    // carries[k] is the carry into bit k; subtraction uses inverted borrows
    logic [WIDTH-1:0] b_eff;
    logic [DIGITS:0] dcy;
    logic [WIDTH-1:0] dec_res;
    logic [WIDTH:0] bin_sum;
    // Nine's complement per digit turns decimal subtract into an add
    assign b_eff = subtract ? ~b : b;
    assign bin_sum = {1'b0, a} + {1'b0, b_eff} + (WIDTH+1)'(subtract ^ cin);
    assign dcy[0] = subtract ^ cin;
    genvar d;
    generate
        for (d = 0; d < DIGITS; d++) begin : g_digit
            logic [3:0] bd;
            logic [4:0] raw;
            logic fix;
            assign bd = subtract ? (`FB_BCD_ONE - b[d*4 +: 4]) : b[d*4 +: 4];
            assign raw = {1'b0, a[d*4 +: 4]} + {1'b0, bd} + 5'(dcy[d]);
            assign fix = raw > 5'h09;
            assign dcy[d+1] = fix;
            assign dec_res[d*4 +: 4] = fix ? 4'(raw + 5'h06) : raw[3:0];
        end
    endgenerate
    genvar k;
    generate
        for (k = 0; k <= WIDTH; k++) begin : g_cy
            if (k == WIDTH) begin : g_top
                assign carries[k] = decimal ? dcy[DIGITS] : bin_sum[WIDTH];
            end else if (k % 4 == 0) begin : g_dig
                assign carries[k] = decimal ? dcy[k/4]
                    : (a[k] ^ b_eff[k] ^ bin_sum[k]);
            end else begin : g_mid
                // Inside a digit the decimal carry is not defined
                assign carries[k] = a[k] ^ b_eff[k] ^ bin_sum[k];
            end
        end
    endgenerate
    assign result = decimal ? dec_res : bin_sum[WIDTH-1:0];
endmodule

// *** bench/function_box_properties.sv ***
// Assertions on the function box ports; sum and carry checks in binary mode.
// Assumes it is bound to every function_box by the line at the foot.
`timescale 1ns/100ps
module function_box_properties
    import function_box_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input function_box_pkg::word_t first_operand,
    input function_box_pkg::word_t second_operand,
    input wire logic carry_flag,
    input function_box_pkg::unit_mode_t unit_mode,
    input function_box_pkg::len_t operand_length,
    input function_box_pkg::word_t sum_result,
    input function_box_pkg::group_t binary_condition_group,
    input function_box_pkg::group_t relational_condition_group,
    input function_box_pkg::group_t operand_state_group,
    input function_box_pkg::ctrl_t carry_length_control_group
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    word_t x, y, keep;
    logic [24:0] wide;
    logic ok;
    assign x = first_operand;
    assign y = second_operand;
    // Lengths past 24 are undefined, so sums are only judged under ok
    assign ok = operand_length <= 5'h18 && !unit_mode[0];
    assign keep = (24'h1 << operand_length) - 24'h1;
    assign wide = {1'b0, x & keep} + {1'b0, y & keep} + 25'(carry_flag);
    sequence inputs_held;
        $stable({x, y, carry_flag, unit_mode, operand_length});
    endsequence
    a_sum_binary: assert property (
        ok |-> sum_result == (wide[23:0] & keep)) else $error("bad sum");
    a_carry_out: assert property (
        ok |-> binary_condition_group[0] == wide[operand_length])
        else $error("bad carry");
    a_borrow_level: assert property (
        binary_condition_group[2:1] ==
        {carry_flag, x < y || x == y && carry_flag}) else $error("bad borrow");
    a_relation_bits: assert property (
        relational_condition_group[2:0] == {x == y, x < y, x > y})
        else $error("bad relation");
    a_state_nonzero: assert property (
        operand_state_group[1:0] == {|y, |x}) else $error("bad state");
    a_least_unit: assert property (
        {binary_condition_group[3], operand_state_group[3]} == (unit_mode[0] ?
        {y[3:0] == 4'h9, x[3:0] == 4'h9} : {y[0], x[0]}))
        else $error("bad least unit");
    a_control_copy: assert property (
        carry_length_control_group ==
        {carry_flag, unit_mode, operand_length}) else $error("bad control");
    a_no_state: assert property (
        inputs_held |-> $stable({sum_result, binary_condition_group}))
        else $error("result moved with inputs held");
endmodule
bind function_box function_box_properties props (.*);

// *** bench/operand_registers.sv ***
// Operand and carry registers that the micro-sequencer moves values into.
// Assumes new values are presented before the rising clock edge.
`timescale 1ns/100ps
module operand_registers
    import function_box_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input function_box_pkg::word_t x_next,
    input function_box_pkg::word_t y_next,
    input wire logic c_next,
    output function_box_pkg::word_t first_operand,
    output function_box_pkg::word_t second_operand,
    output logic carry_flag
);
    // The box keeps nothing, so the operands live here
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            {first_operand, second_operand, carry_flag} <= '0;
        end else begin
            {first_operand, second_operand, carry_flag} <=
                {x_next, y_next, c_next};
        end
    end
endmodule

// *** bench/variable_length_function_box_tb.sv ***
// Bench for the function box: moves operands, then reads the results.
// Assumes operand_registers feed the box and the checker is bound.
`timescale 1ns/100ps
module variable_length_function_box_tb;
    import function_box_pkg::*;
    logic mclk = 1'b0, arst_n = 1'b0, c_next = 1'b0, carry_flag;
    word_t first_operand, second_operand, x_next = '0, y_next = '0;
    word_t sum_result, subtract_result, and_result, or_result, xor_result;
    word_t first_operand_complement, second_operand_complement;
    word_t first_operand_masked, second_operand_masked;
    unit_mode_t unit_mode = UNIT_BIN;
    len_t operand_length = '0;
    group_t port_condition_lines = '0, panel_request_flags = '0;
    group_t memory_fault_flags = '0, binary_condition_group;
    group_t relational_condition_group, operand_state_group;
    ctrl_t carry_length_control_group;
    int failures = 0, num_checks = 0;
    int lens [5] = '{0, 1, 8, 23, 24};
    logic [11:0] irq_bits = 12'hA79;
    wire logic [11:0] grp = {binary_condition_group,
        relational_condition_group, operand_state_group};
    function_box DUT (.*);
    operand_registers src (.*);
    always #10 mclk = ~mclk;
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Results are read by the next micro-instruction
    task automatic move(input word_t x, input word_t y, input logic c,
            input unit_mode_t u, input len_t l);
        @(negedge mclk);
        {x_next, y_next, c_next, operand_length} = {x, y, c, l};
        unit_mode = u;
        @(negedge mclk);
    endtask
    task automatic binary_case(input word_t x, input word_t y,
            input logic c, input unit_mode_t u, input len_t l);
        word_t m;
        logic [24:0] w;
        move(x, y, c, u, l);
        m = (24'h1 << l) - 24'h1;
        w = {1'b0, x & m} + {1'b0, y & m} + 25'(c);
        check({sum_result, subtract_result},
            {w[23:0], x - y - 24'(c)} & {2{m}});
        check({and_result, or_result, xor_result},
            {x & y, x | y, x ^ y} & {3{m}});
        check({first_operand_masked,
            second_operand_masked, first_operand_complement,
            second_operand_complement}, {x, y, ~x, ~y} & {4{m}});
        check(grp[10:7],
            {c, x < y || x == y && c, w[l], l != 0 && x[l - 5'h1]});
        check(carry_length_control_group, {c, u, l});
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        arst_n = 1'b1;
        // Second pair goes negative; both binary codes at edge lengths
        for (int i = 0; i < 10; i++) begin
            binary_case(i > 4 ? 24'h5 : 24'hF0F0F5, i > 4 ? 24'h7 : 24'h0F0F0B,
                i > 4, i[0] ? UNIT_BIN_ALT : UNIT_BIN, len_t'(lens[i % 5]));
        end
        $display("binary lengths done");
        move(24'h158, 24'h263, 1'b1, UNIT_DEC, 5'h18);
        check({sum_result, subtract_result}, 48'h000422_999894);
        check(grp, 12'h623);
        move(24'h999999, 24'h1, 1'b0, UNIT_DEC_ALT, 5'h0C);
        check({sum_result, subtract_result}, 48'h000000_000998);
        check(grp, 12'h19B);
        move(24'h123456, 24'h123456, 1'b1, UNIT_BIN, 5'h18);
        check(grp, 12'h643);
        move(24'h0, 24'h800000, 1'b0, UNIT_BIN, 5'h18);
        check(grp, 12'h222);
        $display("decimal and relations done");
        for (int b = 0; b < 12; b++) begin
            @(negedge mclk);
            {port_condition_lines, panel_request_flags,
                memory_fault_flags} = 12'h1 << b;
            @(negedge mclk);
            check(operand_state_group, {irq_bits[b], 2'h2});
        end
        $display("interrupt summary done");
        close_out();
    end
endmodule
